// >>> wohp_pkg.sv
package wohp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SEL_TWO    = 8'h00;
  localparam logic [7:0] OFS_SEL_THREE  = 8'h04;
  localparam logic [7:0] OFS_CODE_SEL   = 8'h08;
  localparam logic [7:0] OFS_HOLD_TIME  = 8'h0C;
  localparam logic [7:0] OFS_REGEN_CAP  = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;
  // Reset values and hold time limits
  localparam logic [15:0] SEL_TWO_RST   = 16'h0000;
  localparam logic [15:0] SEL_THREE_RST = 16'h0000;
  localparam logic        CODE_SEL_RST  = 1'b0;
  localparam logic [15:0] HOLD_MIN_MS   = 16'h0014;
  localparam logic [15:0] HOLD_MAX_MS   = 16'h03E8;
  localparam logic [15:0] HOLD_RST_MS   = 16'h0014;
  localparam logic [15:0] REGEN_RST     = 16'h0000;
  // Field positions
  localparam int WARN_FIELD_LSB = 12;
  localparam int POSITION_OUT_N_A_FIELD_LSB = 0;
  // Timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int CYC_PER_MS     = CLK_HZ / MS_PER_S;
  // Interrupt bit positions
  localparam int IRQ_WARN       = 0;
  localparam int IRQ_DRIVE_OFF  = 1;
  localparam int IRQ_UNDERVOLT  = 2;
  localparam int IRQ_W          = 3;

  typedef struct packed {
    logic overload;
    logic regen_overload;
    logic alarm;
    logic [2:0] alarm_code;
    logic main_off;
    logic ctrl_off;
    logic undervolt;
    logic position_out_n_a_pos;
    logic [1:0] other_sig;
  } wohp_stat_t;
endpackage

// >>> wohp_ms_tick.sv
`timescale 1ns/1ps
// Millisecond enable pulse from the system clock
module wohp_ms_tick #(
  parameter int DIV = 100000
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Tick out
  output logic      tick
);
  logic [31:0] cnt_reg;

  // Free-running divider; tick is one cycle wide
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(DIV - 1)) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end
endmodule

// >>> wohp_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Warning asserted on overload or regen overload
// - Warning output is active low
// - Field selects none or terminal pair 1-3
// - Output select two resets to zero
// - Shared terminal driven as OR of signals
// - Code select 0 shows alarm codes only
// - Code select 1 shows warnings, alarm overrides
// - Overload bit one low, regen bit two
// - Position_out_n_a on its own output always, and on a terminal via output select three
// - Hold time 20 to 1000 ms, reset 20
// - Supply loss beyond hold turns drive off
// - Short supply loss ignored while timer runs
// - Undervolt and control loss always stop the drive; undervolt alarm only while main supply is off
// - Regen capacity in 10 W, resets zero
module wohp_top #(
  parameter int MS_DIV = wohp_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Status pins from the amplifier
  input  wire wohp_pkg::wohp_stat_t stat_i,
  // Terminal pairs, active low
  output logic      [2:0]          term_out_n,
  // Code outputs, active low
  output logic                     code_bit_one,
  output logic                     code_bit_two,
  output logic                     code_bit_three,
  // Drive and power state
  output logic                     drive_en,
  output logic                     undervolt_alarm,
  output logic                     warn_out_n,
  output logic                     position_out_n_a,
  // Interrupt
  output logic                     irq
);
  wohp_pkg::wohp_stat_t s1_reg;
  wohp_pkg::wohp_stat_t s2_reg;
  logic [15:0] output_select_two;
  logic [15:0] output_select_three;
  logic        warning_code_select;
  logic [15:0] momentary_hold_time;
  logic [15:0] regen_resistor_capacity;
  logic [wohp_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [wohp_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [wohp_pkg::IRQ_W-1:0] irq_ev;
  logic [15:0] hold_cnt_reg;
  logic        holding_reg;
  logic        ms_tick;
  logic        warn_now;
  logic        warn_prev_reg;
  logic        drive_prev_reg;
  logic        uv_prev_reg;
  logic [1:0]  warning_terminal_field;
  logic [1:0]  position_out_n_a_field;
  logic [2:0]  term_act;
  logic [2:0]  code_act;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rd_mux;
  logic [15:0] hold_wr;

  // Two-stage synchroniser for all pins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= stat_i;
      s2_reg <= s1_reg;
    end
  end

  wohp_ms_tick #(
    .DIV (MS_DIV)
  ) u_tick (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .tick    (ms_tick)
  );

  // Bus strobes; ack is one cycle and drops the cycle after
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // Writes below the minimum or above the maximum clamp to the range
  always_comb begin
    hold_wr = wb_dat_i[15:0];
    if (hold_wr < wohp_pkg::HOLD_MIN_MS) begin
      hold_wr = wohp_pkg::HOLD_MIN_MS;
    end else if (hold_wr > wohp_pkg::HOLD_MAX_MS) begin
      hold_wr = wohp_pkg::HOLD_MAX_MS;
    end
  end

  // Configuration registers; new routing takes effect one edge later
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      output_select_two       <= wohp_pkg::SEL_TWO_RST;
      output_select_three     <= wohp_pkg::SEL_THREE_RST;
      warning_code_select     <= wohp_pkg::CODE_SEL_RST;
      momentary_hold_time     <= wohp_pkg::HOLD_RST_MS;
      regen_resistor_capacity <= wohp_pkg::REGEN_RST;
      irq_mask_reg            <= '0;
    end else if (wr_stb) begin
      case (wb_adr_i)
        wohp_pkg::OFS_SEL_TWO: begin
          if (wb_sel_i[0]) output_select_two[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) output_select_two[15:8] <= wb_dat_i[15:8];
        end
        wohp_pkg::OFS_SEL_THREE: begin
          if (wb_sel_i[0]) output_select_three[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) output_select_three[15:8] <= wb_dat_i[15:8];
        end
        wohp_pkg::OFS_CODE_SEL: begin
          if (wb_sel_i[0]) warning_code_select <= wb_dat_i[0];
        end
        wohp_pkg::OFS_HOLD_TIME: begin
          if (&wb_sel_i[1:0]) momentary_hold_time <= hold_wr;
        end
        wohp_pkg::OFS_REGEN_CAP: begin
          if (wb_sel_i[0]) regen_resistor_capacity[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) regen_resistor_capacity[15:8] <= wb_dat_i[15:8];
        end
        wohp_pkg::OFS_IRQ_MASK: begin
          if (wb_sel_i[0]) irq_mask_reg <= wb_dat_i[wohp_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (wb_adr_i)
      wohp_pkg::OFS_SEL_TWO:   rd_mux = {16'h0000, output_select_two};
      wohp_pkg::OFS_SEL_THREE: rd_mux = {16'h0000, output_select_three};
      wohp_pkg::OFS_CODE_SEL:  rd_mux = {31'h0000_0000, warning_code_select};
      wohp_pkg::OFS_HOLD_TIME: rd_mux = {16'h0000, momentary_hold_time};
      wohp_pkg::OFS_REGEN_CAP: rd_mux = {16'h0000, regen_resistor_capacity};
      wohp_pkg::OFS_STATUS:    rd_mux = {hold_cnt_reg, 11'h000, holding_reg, undervolt_alarm,
                                         drive_en, warn_now, 1'b0};
      wohp_pkg::OFS_IRQ_STAT:  rd_mux = {29'h0000_0000, irq_stat_reg};
      wohp_pkg::OFS_IRQ_MASK:  rd_mux = {29'h0000_0000, irq_mask_reg};
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wr_stb | rd_stb;
      if (rd_stb) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Warning condition
  assign warn_now = s2_reg.overload | s2_reg.regen_overload;

  // Hold timer: counts ms while main supply is off, clears on return
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hold_cnt_reg <= 16'h0000;
      holding_reg  <= 1'b0;
    end else if (!s2_reg.main_off) begin
      hold_cnt_reg <= 16'h0000;
      holding_reg  <= 1'b0;
    end else begin
      holding_reg <= 1'b1;
      if (ms_tick && hold_cnt_reg < 16'hFFFF) begin
        hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      end
    end
  end

  // Drive state; control loss and undervolt bypass the hold window.
  // The tick runs free, so one extra tick is needed to be sure the full hold time has passed.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      drive_en        <= 1'b0;
      undervolt_alarm <= 1'b0;
    end else begin
      undervolt_alarm <= s2_reg.undervolt & s2_reg.main_off;
      if (s2_reg.ctrl_off || s2_reg.undervolt) begin
        drive_en <= 1'b0;
      end else if (s2_reg.main_off && hold_cnt_reg > momentary_hold_time) begin
        drive_en <= 1'b0;
      end else begin
        drive_en <= 1'b1;
      end
    end
  end

  // Terminal routing; each pair ORs every signal mapped to it
  assign warning_terminal_field = output_select_two[wohp_pkg::WARN_FIELD_LSB +: 2];
  assign position_out_n_a_field             = output_select_three[wohp_pkg::POSITION_OUT_N_A_FIELD_LSB +: 2];
  always_comb begin
    term_act = 3'b000;
    for (int i = 0; i < 3; i++) begin
      if (warning_terminal_field == 2'(i + 1)) begin
        term_act[i] = term_act[i] | warn_now;
      end
      if (position_out_n_a_field == 2'(i + 1)) begin
        term_act[i] = term_act[i] | s2_reg.position_out_n_a_pos;
      end
    end
    term_act[0] = term_act[0] | s2_reg.other_sig[0];
    term_act[1] = term_act[1] | s2_reg.other_sig[1];
  end

  // Code outputs as active levels; alarm wins over warning
  always_comb begin
    code_act = s2_reg.alarm ? s2_reg.alarm_code : 3'b000;
    if (warning_code_select && !s2_reg.alarm) begin
      if (s2_reg.overload) begin
        code_act = 3'b001;
      end else if (s2_reg.regen_overload) begin
        code_act = 3'b010;
      end
    end
  end

  // Registered active-low pins, glitch free by construction
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      term_out_n       <= 3'b111;
      code_bit_one     <= 1'b1;
      code_bit_two     <= 1'b1;
      code_bit_three   <= 1'b1;
      warn_out_n       <= 1'b1;
      position_out_n_a <= 1'b1;
    end else begin
      term_out_n       <= ~term_act;
      code_bit_one     <= ~code_act[0];
      code_bit_two     <= ~code_act[1];
      code_bit_three   <= ~code_act[2];
      warn_out_n       <= ~warn_now;
      position_out_n_a <= ~s2_reg.position_out_n_a_pos;
    end
  end

  // Sticky events; a set beats a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      warn_prev_reg  <= 1'b0;
      drive_prev_reg <= 1'b0;
      uv_prev_reg    <= 1'b0;
    end else begin
      warn_prev_reg  <= warn_now;
      drive_prev_reg <= drive_en;
      uv_prev_reg    <= undervolt_alarm;
    end
  end

  assign irq_ev[wohp_pkg::IRQ_WARN]      = warn_now & ~warn_prev_reg;
  assign irq_ev[wohp_pkg::IRQ_DRIVE_OFF] = drive_prev_reg & ~drive_en;
  assign irq_ev[wohp_pkg::IRQ_UNDERVOLT] = undervolt_alarm & ~uv_prev_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      if (wr_stb && wb_adr_i == wohp_pkg::OFS_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[wohp_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule

// >>> wohp_host.sv
`timescale 1ns/1ps
// Host input card: latches the photocoupler outputs once per clock
module wohp_host (
  // Clock
  input  wire logic       sys_clk,
  // Observed outputs, active low
  input  wire logic [2:0] term_n,
  input  wire logic [2:0] code_n,
  input  wire logic       warn_n,
  // Latched view
  output logic      [6:0] seen
);
  // One register stage, so the host never reacts inside the cycle of a change
  always_ff @(posedge sys_clk) begin
    seen <= {warn_n, code_n, term_n};
  end
endmodule

// >>> wohp_chk.sv
`timescale 1ns/1ps
// Watches warning, codes, drive and bus timing at the top ports
module wohp_chk #(
  parameter int MS_DIV = wohp_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rstn,
  // Bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic                 wb_ack_o,
  // Pins
  input wire wohp_pkg::wohp_stat_t stat_i,
  input wire logic                 code_bit_one,
  input wire logic                 code_bit_two,
  input wire logic                 code_bit_three,
  input wire logic                 drive_en,
  input wire logic                 warn_out_n,
  input wire logic                 irq
);
  logic csel_reg;
  int   moff_cnt;
  logic csel_wr;
  assign csel_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  // Shadow of the code selection; it lags, so code checks want five steady cycles
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      csel_reg <= 1'b0;
    end else if (csel_wr && wb_adr_i == wohp_pkg::OFS_CODE_SEL) begin
      csel_reg <= wb_dat_i[0];
    end
  end
  // Length of the current supply loss in cycles
  always_ff @(posedge sys_clk) begin
    if (!rstn || !stat_i.main_off) begin
      moff_cnt <= 0;
    end else if (moff_cnt < (int'(wohp_pkg::HOLD_MAX_MS) + 1) * MS_DIV) begin
      moff_cnt <= moff_cnt + 1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_warn_set: assert property ((stat_i.overload || stat_i.regen_overload)[*5] |-> !warn_out_n)
    else $error("warning not asserted");
  a_warn_idle: assert property ((!stat_i.overload && !stat_i.regen_overload)[*5] |-> warn_out_n)
    else $error("warning not released");
  a_code_ovl: assert property ((csel_reg && stat_i.overload && !stat_i.alarm)[*5]
    |-> {code_bit_three, code_bit_two, code_bit_one} == 3'h6) else $error("overload code wrong");
  a_code_regen: assert property ((csel_reg && !stat_i.overload && stat_i.regen_overload && !stat_i.alarm)[*5]
    |-> {code_bit_three, code_bit_two, code_bit_one} == 3'h5) else $error("regen code wrong");
  a_code_quiet: assert property ((!csel_reg && !stat_i.alarm)[*5]
    |-> code_bit_one && code_bit_two && code_bit_three) else $error("code shown without alarm");
  a_alarm_wins: assert property ((stat_i.alarm && $stable(stat_i.alarm_code))[*5]
    |-> {code_bit_three, code_bit_two, code_bit_one} == ~stat_i.alarm_code) else $error("alarm code wrong");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_fast_off: assert property ((stat_i.ctrl_off || stat_i.undervolt)[*5] |-> !drive_en)
    else $error("drive not off on fast fault");
  a_hold_min: assert property ($fell(drive_en) && !stat_i.ctrl_off && !stat_i.undervolt && !stat_i.alarm
    |-> moff_cnt > int'(wohp_pkg::HOLD_MIN_MS) * MS_DIV) else $error("drive off before hold time");
  c_warn: cover property ($fell(warn_out_n));
  c_off: cover property ($fell(drive_en));
  c_irq: cover property ($rose(irq));
endmodule
bind wohp_top wohp_chk #(.MS_DIV(MS_DIV)) u_wohp_chk (
  .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .stat_i(stat_i), .code_bit_one(code_bit_one), .code_bit_two(code_bit_two),
  .code_bit_three(code_bit_three), .drive_en(drive_en), .warn_out_n(warn_out_n), .irq(irq)
);

// >>> wohp_top_tb.sv
`timescale 1ns/1ps
module wohp_top_tb;
  logic                 sys_clk, rstn, cyc, stb, we, ack, irq, drv, uva, c1, c2, c3, warn, ia, pos;
  logic [7:0]           adr;
  logic [3:0]           sel;
  logic [31:0]          wdat, rdat, rv;
  logic [2:0]           term;
  logic [6:0]           seen;
  wohp_pkg::wohp_stat_t st;
  int                   fails, n_checks, cyc_cnt, i;
  wohp_top #(.MS_DIV(10)) u_wohp_top (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .stat_i(st), .term_out_n(term),
    .code_bit_one(c1), .code_bit_two(c2), .code_bit_three(c3), .drive_en(drv), .undervolt_alarm(uva),
    .warn_out_n(warn), .position_out_n_a(pos), .irq(irq));
  wohp_host u_wohp_host (.sys_clk(sys_clk), .term_n(term), .code_n({c3, c2, c1}), .warn_n(warn), .seen(seen));
  always #5 sys_clk = ~sys_clk;
  task automatic print_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic pin(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Classic single cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1) @(posedge sys_clk);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  // Host view is {warn, code three..one, terminals 3..1}; pins need three edges plus the host's one
  task automatic chp(input logic [6:0] e);
    pin(6);
    chk({25'h0, seen}, {25'h0, e});
  endtask
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {cyc, stb, we, adr, wdat, st} = '0;
    sel = 4'hF;
    {fails, n_checks, cyc_cnt} = '0;
    pin(2);
    rstn <= 1'b1;
    rdc(wohp_pkg::OFS_SEL_TWO, 32'h0);
    rdc(wohp_pkg::OFS_SEL_THREE, 32'h0);
    rdc(wohp_pkg::OFS_CODE_SEL, 32'h0);
    rdc(wohp_pkg::OFS_HOLD_TIME, 32'h14);
    rdc(wohp_pkg::OFS_REGEN_CAP, 32'h0);
    rdc(8'h3C, 32'h0);
    st.overload <= 1'b1;
    chp(7'h3F);
    for (i = 1; i < 4; i++) begin
      bus(1'b1, wohp_pkg::OFS_SEL_TWO, 32'(i) << 12);
      chp(7'h3F & ~(7'h1 << (i - 1)));
    end
    st.other_sig <= 2'h2;
    chp(7'h39);
    st.overload <= 1'b0;
    chp(7'h7D);
    st.other_sig <= 2'h0;
    bus(1'b1, wohp_pkg::OFS_SEL_TWO, 32'h0);
    bus(1'b1, wohp_pkg::OFS_CODE_SEL, 32'h1);
    st.overload <= 1'b1;
    chp(7'h37);
    {st.overload, st.regen_overload} <= 2'b01;
    chp(7'h2F);
    {st.alarm, st.alarm_code} <= 4'hD;
    chp(7'h17);
    st <= '{position_out_n_a_pos: 1'b1, default: '0};
    chp(7'h7F);
    chk(pos, 1'b0);
    bus(1'b1, wohp_pkg::OFS_SEL_THREE, 32'h1);
    chp(7'h7E);
    bus(1'b1, wohp_pkg::OFS_REGEN_CAP, 32'hA);
    rdc(wohp_pkg::OFS_REGEN_CAP, 32'hA);
    bus(1'b1, wohp_pkg::OFS_HOLD_TIME, 32'h7D0);
    rdc(wohp_pkg::OFS_HOLD_TIME, 32'h3E8);
    bus(1'b1, wohp_pkg::OFS_HOLD_TIME, 32'h5);
    rdc(wohp_pkg::OFS_HOLD_TIME, 32'h14);
    st.main_off <= 1'b1;
    pin(100);
    chk(drv, 1'b1);
    st.main_off <= 1'b0;
    pin(6);
    bus(1'b0, wohp_pkg::OFS_STATUS, 32'h0);
    chk(rv[31:16], 16'h0);
    st.main_off <= 1'b1;
    pin(260);
    chk(drv, 1'b0);
    st.undervolt <= 1'b1;
    pin(6);
    chk(uva, 1'b1);
    st <= '0;
    bus(1'b1, wohp_pkg::OFS_IRQ_MASK, 32'h0);
    pin(3);
    ia = irq;
    chk(drv, 1'b1);
    rdc(wohp_pkg::OFS_IRQ_STAT, 32'h7);
    bus(1'b1, wohp_pkg::OFS_IRQ_MASK, 32'h7);
    pin(3);
    chk(ia, 1'b0);
    chk(irq, 1'b1);
    bus(1'b1, wohp_pkg::OFS_IRQ_STAT, 32'h7);
    rdc(wohp_pkg::OFS_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    st.overload <= 1'b1;
    pin(6);
    rdc(wohp_pkg::OFS_IRQ_STAT, 32'h1);
    st.ctrl_off <= 1'b1;
    pin(6);
    chk(drv, 1'b0);
    bus(1'b1, wohp_pkg::OFS_CODE_SEL, 32'h0);
    {st.alarm, st.alarm_code} <= 4'hB;
    chp(7'h27);
    print_verdict();
  end
endmodule
